// [otc_pkg.sv]
// Shared constants for the overtemperature threshold compare block.
`default_nettype none
package otc_pkg;
   // Bus geometry: the register index is the byte address divided by four.
   localparam int          ADDR_W        = 18;
   localparam int          IDX_W         = 16;
   // Register indices.
   localparam logic [15:0] IDX_TRIM2     = 16'hfe74;
   localparam logic [15:0] IDX_THR1      = 16'hfe75;
   localparam logic [15:0] IDX_THR2      = 16'hfe76;
   localparam logic [15:0] IDX_READ1     = 16'hfed7;
   localparam logic [15:0] IDX_READ2     = 16'hfed8;
   localparam logic [15:0] IDX_IRQ_STAT  = 16'hff00;
   localparam logic [15:0] IDX_IRQ_MASK  = 16'hff01;
   localparam logic [15:0] IDX_FLAGS     = 16'hff02;
   localparam logic [15:0] IDX_LIMIT1    = 16'hff03;
   localparam logic [15:0] IDX_LIMIT2    = 16'hff04;
   // Field layout.
   localparam int          N_CHAN        = 2;
   localparam int          THR_W         = 8;
   localparam int          CMP_W         = 9;
   localparam int          TRIM_POL_BIT  = 7;
   localparam int          TRIM_MAG_W    = 7;
   localparam int          TRIM_SHIFT    = 10;
   // Reset values.
   localparam logic [7:0]  TRIM_RST      = 8'h00;
   localparam logic [7:0]  THR_RST       = 8'h00;
   localparam logic [1:0]  MASK_RST      = 2'h0;
   // Threshold step in microvolts and the width of the limit readback.
   localparam int          THR_STEP_UV   = 3125;
   localparam int          LIMIT_W       = 20;
   // Debounce timing.
   localparam int          CLK_MHZ       = 250;
   localparam int          DEBOUNCE_MS   = 100;
   localparam int          DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam int          CNT_W         = 25;
   // Bus responses.
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// [otc_cmp_if.sv]
// Link between the register block and one threshold comparator channel.
`timescale 1ns/1ns
`default_nettype none
interface otc_cmp_if import otc_pkg::*; ();
   logic [THR_W-1:0] thr;
   logic [CMP_W-1:0] reading;
   logic             cond;
   logic             flag;
   modport ctrl (output thr, output reading, input cond, input flag);
   modport chan (input thr, input reading, output cond, output flag);
endinterface
`default_nettype wire

// [otc_trim.sv]
// Gain trim applied to the second sensor reading.
`timescale 1ns/1ns
`default_nettype none
module otc_trim import otc_pkg::*; #(
   parameter int ADC_W = 12
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [7:0]       trim,
   input  wire logic [ADC_W-1:0] raw,
   output logic      [ADC_W-1:0] trimmed
);
   typedef struct packed {
      logic [ADC_W-1:0] out;
   } otc_trim_s;

   otc_trim_s                     st;
   otc_trim_s                     next_st;
   logic [ADC_W+TRIM_MAG_W-1:0]   prod;
   logic [ADC_W-1:0]              delta;
   logic [ADC_W:0]                sum;

   // Correction is a fraction of the reading; results saturate at both ends.
   always_comb begin
      next_st = st;
      prod  = {{TRIM_MAG_W{1'b0}}, raw} * {{ADC_W{1'b0}}, trim[TRIM_MAG_W-1:0]};
      delta = ADC_W'(prod >> TRIM_SHIFT);
      if (trim[TRIM_POL_BIT]) begin
         sum = {1'b0, raw} - {1'b0, delta};
         next_st.out = sum[ADC_W] ? '0 : sum[ADC_W-1:0];
      end else begin
         sum = {1'b0, raw} + {1'b0, delta};
         next_st.out = sum[ADC_W] ? '1 : sum[ADC_W-1:0];
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) st <= '0;
      else          st <= next_st;
   end

   assign trimmed = st.out;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   trim_neg_a: assert property (trim[TRIM_POL_BIT] |=> trimmed <= $past(raw))
      else $error("negative trim raised the reading");
   trim_pos_a: assert property (!trim[TRIM_POL_BIT] |=> trimmed >= $past(raw))
      else $error("positive trim lowered the reading");
   trim_zero_a: assert property (trim[TRIM_MAG_W-1:0] == '0 |=> trimmed == $past(raw))
      else $error("zero trim magnitude changed the reading");
endmodule // otc_trim
`default_nettype wire

// [otc_chan.sv]
// One threshold comparator with debounce of its overtemperature flag.
`timescale 1ns/1ns
`default_nettype none
module otc_chan import otc_pkg::*; #(
   parameter int DEB_CYC = DEBOUNCE_CYC
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   otc_cmp_if.chan   cmp
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             flag;
   } otc_chan_s;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(DEB_CYC - 1);

   otc_chan_s        st;
   otc_chan_s        next_st;
   logic [CMP_W-1:0] wide_thr;

   assign wide_thr = {1'b0, cmp.thr};
   assign cmp.cond = wide_thr > cmp.reading;

   // Count uninterrupted cycles of the condition; the flag follows at the end.
   always_comb begin
      next_st = st;
      if (!cmp.cond) begin
         next_st.count = '0;
         next_st.flag  = 1'b0;
      end else if (st.count != LAST) begin
         next_st.count = st.count + 1'b1;
      end else begin
         next_st.flag = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) st <= '0;
      else          st <= next_st;
   end

   assign cmp.flag = st.flag;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence cond_at_last;
      cmp.cond && st.count == LAST;
   endsequence

   flag_needs_cond_a: assert property (cmp.flag |-> $past(cmp.cond))
      else $error("flag high without the compare condition");
   flag_rise_count_a: assert property ($rose(cmp.flag) |-> $past(st.count) == LAST)
      else $error("flag rose before the debounce interval");
   flag_sets_a: assert property (cond_at_last |=> cmp.flag)
      else $error("flag missed at end of debounce");
   restart_cnt_a: assert property (!cmp.cond |=> st.count == '0 && !cmp.flag)
      else $error("debounce did not restart on dropout");
endmodule // otc_chan
`default_nettype wire

// [otc_top.sv]
// Register block, AXI4-Lite slave and interrupt logic of the overtemperature compare.
//
// Contract
// - Bit 7 of the second sensor trim selects negative gain when one, positive when zero.
// - Bits 6 to 0 of the second sensor trim set the size of the gain correction.
// - The first threshold is an 8-bit read-write register at index 0xfe75.
// - Each threshold is widened to 9 bits with a zero above the programmed bits.
// - The first threshold is compared with the top nine bits of the first sensor reading.
// - A threshold above the reading sets the matching overtemperature flag.
// - The first flag rises only after the condition has held for 100 ms.
// - One threshold step is 3.125 mV, so 256 codes span 0 to 796.875 mV.
// - The second threshold is its own register at index 0xfe76.
// - The second flag rises only after its condition has held for 100 ms.
// - The second threshold is compared with the top nine bits of the second reading.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module otc_top import otc_pkg::*; #(
   parameter int ADC_W   = 12,
   parameter int DEB_CYC = DEBOUNCE_CYC
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [ADC_W-1:0]  temp_sensor_one_adc,
   input  wire logic [ADC_W-1:0]  temp_sensor_two_adc,
   output logic                   overtemp_prot_one_flag,
   output logic                   overtemp_prot_two_flag,
   output logic                   irq
);
   typedef struct packed {
      logic                              aw_got;
      logic [IDX_W-1:0]                  aw_idx;
      logic                              w_got;
      logic [31:0]                       wdata;
      logic [3:0]                        wstrb;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              rvalid;
      logic [31:0]                       rdata;
      logic [1:0]                        rresp;
      logic [7:0]                        trim2;
      logic [N_CHAN-1:0][THR_W-1:0]      thr;
      logic [N_CHAN-1:0][ADC_W-1:0]      rd;
      logic [N_CHAN-1:0]                 flag_d;
      logic [N_CHAN-1:0]                 irq_stat;
      logic [N_CHAN-1:0]                 irq_mask;
   } otc_top_s;

   otc_top_s          st;
   otc_top_s          next_st;
   logic [ADC_W-1:0]  trimmed;
   logic [N_CHAN-1:0] flag;
   logic [N_CHAN-1:0] cond;
   logic [N_CHAN-1:0] flag_rise;
   logic [N_CHAN-1:0] stat_clr;
   logic              wr_en;
   logic [IDX_W-1:0]  wr_idx;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              rd_en;
   logic [IDX_W-1:0]  rd_idx;
   logic [31:0]       rd_word;
   logic              rd_hit;
   logic              wr_hit;

   otc_cmp_if cmp [N_CHAN] ();

   otc_trim #(
      .ADC_W   (ADC_W)
   ) u_trim (
      .aclk    (aclk),
      .aresetn (aresetn),
      .trim    (st.trim2),
      .raw     (temp_sensor_two_adc),
      .trimmed (trimmed)
   );

   // One comparator per channel, fed with its threshold and registered reading.
   for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
      assign cmp[g].thr     = st.thr[g];
      assign cmp[g].reading = st.rd[g][ADC_W-1 -: CMP_W];
      assign flag[g]        = cmp[g].flag;
      assign cond[g]        = cmp[g].cond;
      otc_chan #(
         .DEB_CYC (DEB_CYC)
      ) u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .cmp     (cmp[g])
      );
   end

   // Handshake readies: one write and one read in flight at a time.
   // Shutting the write channels while bvalid stands stops a second write overtaking it.
   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready  = !st.w_got && !st.bvalid;
   assign s_axi_arready = !st.rvalid;

   // Effective write: address and data may arrive in either order.
   always_comb begin
      wr_idx  = st.aw_got ? st.aw_idx : s_axi_awaddr[ADDR_W-1:2];
      wr_data = st.w_got ? st.wdata : s_axi_wdata;
      wr_strb = st.w_got ? st.wstrb : s_axi_wstrb;
      wr_en   = (st.aw_got || (s_axi_awvalid && s_axi_awready))
             && (st.w_got || (s_axi_wvalid && s_axi_wready))
             && !st.bvalid;
      rd_en   = s_axi_arvalid && s_axi_arready;
      rd_idx  = s_axi_araddr[ADDR_W-1:2];
   end

   // Write decode: known indices answer OKAY, read-only ones ignore the data.
   always_comb begin
      case (wr_idx)
         IDX_TRIM2, IDX_THR1, IDX_THR2, IDX_IRQ_MASK,
         IDX_READ1, IDX_READ2, IDX_IRQ_STAT, IDX_FLAGS,
         IDX_LIMIT1, IDX_LIMIT2: wr_hit = 1'b1;
         default:                wr_hit = 1'b0;
      endcase
   end

   // Read mux; narrow registers sit in the low bits, upper bits read zero.
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case (rd_idx)
         IDX_TRIM2:    rd_word = {24'h0, st.trim2};
         IDX_THR1:     rd_word = {24'h0, st.thr[0]};
         IDX_THR2:     rd_word = {24'h0, st.thr[1]};
         IDX_READ1:    rd_word = 32'(st.rd[0]);
         IDX_READ2:    rd_word = 32'(st.rd[1]);
         IDX_IRQ_STAT: rd_word = 32'(st.irq_stat);
         IDX_IRQ_MASK: rd_word = 32'(st.irq_mask);
         IDX_FLAGS:    rd_word = 32'(flag);
         IDX_LIMIT1:   rd_word = 32'(st.thr[0]) * 32'(THR_STEP_UV);
         IDX_LIMIT2:   rd_word = 32'(st.thr[1]) * 32'(THR_STEP_UV);
         default:      rd_hit  = 1'b0;
      endcase
   end

   // Interrupt events: a flag rising, and a status read that clears.
   assign flag_rise = flag & ~st.flag_d;
   assign stat_clr  = (rd_en && rd_idx == IDX_IRQ_STAT) ? '1 : '0;

   // Next-state logic for the bus channels and the register file.
   always_comb begin
      next_st        = st;
      next_st.rd[0]  = temp_sensor_one_adc;
      next_st.rd[1]  = trimmed;
      next_st.flag_d = flag;
      // Set wins over the clearing read.
      next_st.irq_stat = (st.irq_stat & ~stat_clr) | flag_rise;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (wr_en) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (wr_strb[0]) begin
            case (wr_idx)
               IDX_TRIM2:    next_st.trim2 = wr_data[7:0];
               IDX_THR1:     next_st.thr[0] = wr_data[7:0];
               IDX_THR2:     next_st.thr[1] = wr_data[7:0];
               IDX_IRQ_MASK: next_st.irq_mask = wr_data[N_CHAN-1:0];
               default:      next_st.trim2 = st.trim2;
            endcase
         end
      end else if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (rd_en) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_word;
         next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st          <= '0;
         st.trim2    <= TRIM_RST;
         st.thr      <= {N_CHAN{THR_RST}};
         st.irq_mask <= MASK_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs.
   assign s_axi_bvalid           = st.bvalid;
   assign s_axi_bresp            = st.bresp;
   assign s_axi_rvalid           = st.rvalid;
   assign s_axi_rdata            = st.rdata;
   assign s_axi_rresp            = st.rresp;
   assign overtemp_prot_one_flag = flag[0];
   assign overtemp_prot_two_flag = flag[1];
   assign irq                    = |(st.irq_stat & st.irq_mask);

   // Helper: run length of the second condition, for the debounce check.
   logic [31:0] run2;
   always_ff @(posedge aclk) begin
      if (!aresetn)     run2 <= '0;
      else if (!cond[1]) run2 <= '0;
      else if (run2 != '1) run2 <= run2 + 1'b1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence thr1_write;
      wr_en && wr_idx == IDX_THR1 && wr_strb[0];
   endsequence
   sequence thr2_write;
      wr_en && wr_idx == IDX_THR2 && wr_strb[0];
   endsequence
   sequence mask_write;
      wr_en && wr_idx == IDX_IRQ_MASK && wr_strb[0];
   endsequence
   sequence trim_write;
      wr_en && wr_idx == IDX_TRIM2 && wr_strb[0];
   endsequence

   thr1_store_a: assert property (thr1_write |=> st.thr[0] == $past(wr_data[7:0]))
      else $error("first threshold write not stored");
   thr2_store_a: assert property (thr2_write |=> st.thr[1] == $past(wr_data[7:0]))
      else $error("second threshold write not stored");
   cmp_one_a: assert property (cond[0] == ({1'b0, st.thr[0]} > st.rd[0][ADC_W-1 -: CMP_W]))
      else $error("first compare does not match threshold and reading");
   cmp_two_a: assert property (cond[1] == ({1'b0, st.thr[1]} > st.rd[1][ADC_W-1 -: CMP_W]))
      else $error("second compare does not match threshold and reading");
   flag_two_deb_a: assert property ($rose(flag[1]) |-> run2 >= 32'(DEB_CYC))
      else $error("second flag rose before its debounce interval");
   limit_read_a: assert property (rd_en && rd_idx == IDX_LIMIT1 |=>
      s_axi_rdata == 32'($past(st.thr[0])) * 32'(THR_STEP_UV))
      else $error("limit readback wrong");
   limit_two_a: assert property (rd_en && rd_idx == IDX_LIMIT2 |=>
      s_axi_rdata == 32'($past(st.thr[1])) * 32'(THR_STEP_UV))
      else $error("second limit wrong");
   stat_set_a: assert property (flag_rise[0] |=> st.irq_stat[0])
      else $error("flag rise not latched in status");
   stat_set_two_a: assert property (flag_rise[1] |=> st.irq_stat[1])
      else $error("second rise not latched");
   stat_clear_a: assert property (stat_clr[0] && !flag_rise[0] |=> !st.irq_stat[0])
      else $error("status not cleared");
   // A mask write in the same cycle may lawfully drop the line.
   irq_hold_a: assert property (st.irq_stat[1] && st.irq_mask[1] && !stat_clr[1]
      && !(wr_en && wr_idx == IDX_IRQ_MASK) |=> irq)
      else $error("interrupt dropped while status pending");
   // Register stores, bus discipline and flag release.
   trim_store_a: assert property (trim_write |=> st.trim2 == $past(wr_data[7:0]))
      else $error("trim not stored");
   mask_store_a: assert property (mask_write |=> st.irq_mask == $past(wr_data[N_CHAN-1:0]))
      else $error("mask not stored");
   b_answer_a: assert property (wr_en |=> s_axi_bvalid)
      else $error("write not answered");
   r_answer_a: assert property (rd_en |=> s_axi_rvalid)
      else $error("read not answered");
   w_shut_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open");
   ar_shut_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read channel open");
   bad_write_a: assert property (wr_en && !wr_hit |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   flag_drop_a: assert property (!cond[0] |=> !overtemp_prot_one_flag)
      else $error("first flag held");
   flag_drop_two_a: assert property (!cond[1] |=> !overtemp_prot_two_flag)
      else $error("second flag held");
endmodule // otc_top
`default_nettype wire

// [otc_unused_placeholder_never.sv]
// Intentionally empty compile unit.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the overtemperature threshold compare block.
`timescale 1ns/1ns
`default_nettype none
module testbench import otc_pkg::*;;
   localparam int     DEB = 16;
   localparam int     AW  = 12;
   logic              aclk    = 1'h0;
   logic              aresetn = 1'h0;
   logic [ADDR_W-1:0] awaddr  = '0;
   logic [ADDR_W-1:0] araddr  = '0;
   logic [31:0]       wdata   = '0;
   logic [3:0]        wstrb   = '0;
   logic              awvalid = 1'h0;
   logic              wvalid  = 1'h0;
   logic              bready  = 1'h0;
   logic              arvalid = 1'h0;
   logic              rready  = 1'h0;
   logic [AW-1:0]     adc1    = 12'hfff;
   logic [AW-1:0]     adc2    = 12'hfff;
   logic [31:0]       rdata;
   logic [1:0]        bresp, rresp, flag;
   logic              awready, wready, bvalid, arready, rvalid, irq;
   int                num_errors = 0;
   int                num_checks = 0;
   int                seed       = 72;

   // Free-running 250 MHz clock.
   always #2 aclk = ~aclk;

   // Design with a short debounce count.
   otc_top #(.ADC_W(AW), .DEB_CYC(DEB)) DUT (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .s_axi_awaddr           (awaddr),
      .s_axi_awvalid          (awvalid),
      .s_axi_awready          (awready),
      .s_axi_wdata            (wdata),
      .s_axi_wstrb            (wstrb),
      .s_axi_wvalid           (wvalid),
      .s_axi_wready           (wready),
      .s_axi_bresp            (bresp),
      .s_axi_bvalid           (bvalid),
      .s_axi_bready           (bready),
      .s_axi_araddr           (araddr),
      .s_axi_arvalid          (arvalid),
      .s_axi_arready          (arready),
      .s_axi_rdata            (rdata),
      .s_axi_rresp            (rresp),
      .s_axi_rvalid           (rvalid),
      .s_axi_rready           (rready),
      .temp_sensor_one_adc    (adc1),
      .temp_sensor_two_adc    (adc2),
      .overtemp_prot_one_flag (flag[0]),
      .overtemp_prot_two_flag (flag[1]),
      .irq                    (irq)
   );

   // Comparisons, one task for each kind of result.
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Write one word; handshakes are sampled at the negedge before the taking edge.
   task automatic axi_write(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] resp);
      logic a;
      logic w;
      logic b;
      int   n;
      b = 1'h0;
      n = 0;
      @(posedge aclk);
      awaddr  <= {idx, 2'h0};
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!b && n < 50) begin
         @(negedge aclk);
         a    = awvalid && awready;
         w    = wvalid && wready;
         b    = bvalid && bready;
         resp = bresp;
         n++;
         @(posedge aclk);
         if (a)
            awvalid <= 1'h0;
         if (w)
            wvalid <= 1'h0;
      end
      bready <= 1'h0;
      check_bit("write answer", 1'h1, b);
   endtask

   // Read one word; data are sampled at the negedge before the edge where rvalid meets rready.
   task automatic axi_read(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
      logic a;
      logic b;
      int   n;
      b = 1'h0;
      n = 0;
      @(posedge aclk);
      araddr  <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!b && n < 50) begin
         @(negedge aclk);
         a    = arvalid && arready;
         b    = rvalid && rready;
         d    = rdata;
         resp = rresp;
         n++;
         @(posedge aclk);
         if (a)
            arvalid <= 1'h0;
      end
      rready <= 1'h0;
      check_bit("read answer", 1'h1, b);
   endtask

   // Register access with the response expected to be OKAY.
   task automatic wr_chk(input logic [15:0] idx, input logic [31:0] d);
      logic [1:0] r;
      axi_write(idx, d, r);
      check_resp("write resp", RESP_OKAY, r);
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(idx, d, r);
      check_resp(what, RESP_OKAY, r);
      check_word(what, exp, d);
   endtask

   // Drive a sensor so that its top nine bits equal top; low bits are random.
   task automatic set_adc(input int ch, input logic [8:0] top);
      logic [AW-1:0] v;
      v = {top, 3'($random(seed))};
      @(posedge aclk);
      if (ch == 0)
         adc1 <= v;
      else
         adc2 <= v;
   endtask
   task automatic chk_flag(input int ch, input logic exp);
      @(negedge aclk);
      check_bit("flag", exp, flag[ch]);
   endtask

   // Expected compare result and trimmed reading.
   function automatic logic cmp_exp(input logic [7:0] thr, input logic [8:0] top);
      return {1'h0, thr} > top;
   endfunction
   function automatic logic [AW-1:0] trim_exp(input logic [7:0] t, input logic [AW-1:0] raw);
      logic [AW+6:0] p;
      logic [AW:0]   s;
      p = (raw * t[6:0]) >> TRIM_SHIFT;
      s = t[7] ? {1'h0, raw} - p[AW:0] : {1'h0, raw} + p[AW:0];
      if (s[AW])
         return t[7] ? '0 : '1;
      return s[AW-1:0];
   endfunction

   // Closing report.
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Cut a hung run short.
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      logic [15:0] idx [3];
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  v;
      logic [8:0]  top;
      idx = '{IDX_TRIM2, IDX_THR1, IDX_THR2};
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (idx[j]) rd_chk(idx[j], 32'h0, "reset value");
      rd_chk(IDX_IRQ_STAT, 32'h0, "status reset");
      // Unmapped places answer with an error.
      axi_read(16'h0010, d, r);
      check_resp("unmapped read", RESP_SLVERR, r);
      axi_write(16'h0011, 32'h5a, r);
      check_resp("unmapped write", RESP_SLVERR, r);
      for (int i = 0; i < 3; i++) begin
         foreach (idx[j]) begin
            v = 8'($random(seed));
            wr_chk(idx[j], {24'h0, v});
            rd_chk(idx[j], {24'h0, v}, "reg readback");
            if (j > 0)
               rd_chk(j == 1 ? IDX_LIMIT1 : IDX_LIMIT2, v * THR_STEP_UV, "limit");
         end
      end
      wr_chk(IDX_TRIM2, 32'h0);
      // boundaries and random codes; keeps codes off the extremes.
      for (int ch = 0; ch < 2; ch++) begin
         for (int k = 0; k < 6; k++) begin
            v = 8'h08 + 8'($unsigned($random(seed)) % 240);
            case (k)
               0: top = {1'h0, v} - 9'h1;
               1: top = {1'h0, v};
               2: top = {1'h0, v} + 9'h1;
               3: top = {1'h1, 8'($random(seed))};
               4: top = 9'h0;
               default: top = 9'($random(seed));
            endcase
            wr_chk(ch ? IDX_THR2 : IDX_THR1, {24'h0, v});
            set_adc(ch, top);
            repeat (DEB) @(posedge aclk);
            chk_flag(ch, 1'h0);
            repeat (2) @(posedge aclk);
            chk_flag(ch, cmp_exp(v, top));
            set_adc(ch, 9'h1ff);
            repeat (3) @(posedge aclk);
            chk_flag(ch, 1'h0);
         end
      end
      wr_chk(IDX_THR1, 32'h80);
      set_adc(0, 9'h7f);
      repeat (DEB - 3) @(posedge aclk);
      set_adc(0, 9'h1ff);
      repeat (2) @(posedge aclk);
      set_adc(0, 9'h7f);
      repeat (DEB - 3) @(posedge aclk);
      chk_flag(0, 1'h0);
      repeat (8) @(posedge aclk);
      chk_flag(0, 1'h1);
      // Status, mask and interrupt line.
      rd_chk(IDX_FLAGS, 32'h1, "live flags");
      @(negedge aclk);
      check_bit("irq masked", 1'h0, irq);
      rd_chk(IDX_IRQ_STAT, 32'h3, "status");
      rd_chk(IDX_IRQ_STAT, 32'h0, "status cleared");
      wr_chk(IDX_IRQ_MASK, 32'h2);
      rd_chk(IDX_IRQ_MASK, 32'h2, "mask");
      wr_chk(IDX_THR2, 32'h80);
      set_adc(1, 9'h10);
      repeat (DEB + 8) @(posedge aclk);
      @(negedge aclk);
      check_bit("irq raised", 1'h1, irq);
      rd_chk(IDX_IRQ_STAT, 32'h2, "status two");
      @(negedge aclk);
      check_bit("irq cleared", 1'h0, irq);
      set_adc(1, 9'h1ff);
      // gain trim with corner and random settings.
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : 8'($random(seed));
         wr_chk(IDX_TRIM2, {24'h0, v});
         d = 32'($random(seed));
         @(posedge aclk);
         adc2 <= d[AW-1:0];
         adc1 <= d[2*AW-1:AW];
         repeat (4) @(posedge aclk);
         rd_chk(IDX_READ2, {20'h0, trim_exp(v, d[AW-1:0])}, "trimmed");
         rd_chk(IDX_READ1, {20'h0, d[2*AW-1:AW]}, "reading one");
      end
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
